// [hw/rpd_arrival.sv]
// Signal arrival detector built on a signal strength jump detector
// Assumes one-cycle bit strobes from bit clock recovery and a held config
`timescale 1ns/10ps
`include "rpd_regs.svh"
module rpd_arrival
  import rpd_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       clear_i,
  input  wire logic       afc_i,
  input  wire logic [7:0] jump_i,
  // Receive stream
  input  wire logic [7:0] rssi_i,
  input  wire logic       bit_i,
  input  wire logic       bit_vld_i,
  // Result
  output logic            arrived_o,
  output logic            afc_shot_o
);
  rpd_arr_state_type state_r;
  logic [7:0] base_r;
  logic [4:0] bits_r;
  logic [4:0] tog_r;
  logic       prev_r;
  logic [8:0] diff;
  logic [4:0] need;

  assign diff = {1'b0, rssi_i} - {1'b0, base_r};
  assign need = afc_i ? `RPD_ARR_AFC_BITS : `RPD_ARR_BITS;

  // Jump detection, then one or two bytes of transitions
  always_ff @(posedge clk_i) begin
    afc_shot_o <= 1'b0;
    if (rst_i || clear_i) begin
      state_r   <= ARR_IDLE;
      base_r    <= 8'h00;
      bits_r    <= 5'h00;
      tog_r     <= 5'h00;
      prev_r    <= 1'b0;
      arrived_o <= 1'b0;
    end else begin
      case (state_r)
        ARR_IDLE: begin
          if (!diff[8] && diff[7:0] > jump_i) begin
            state_r <= ARR_COUNT;
            bits_r  <= 5'h00;
            tog_r   <= 5'h00;
          end else if (bit_vld_i) begin
            base_r <= rssi_i;
          end
        end
        ARR_COUNT: begin
          if (bit_vld_i) begin
            prev_r <= bit_i;
            bits_r <= bits_r + 5'h01;
            if (bits_r != 5'h00 && bit_i != prev_r) begin
              tog_r <= tog_r + 5'h01;
            end
            if (bits_r + 5'h01 == need) begin
              if (tog_r >= `RPD_ARR_MIN_TOG) begin
                state_r    <= ARR_DONE;
                arrived_o  <= 1'b1;
                afc_shot_o <= afc_i;
              end else begin
                state_r <= ARR_IDLE;
                base_r  <= rssi_i;
              end
            end
          end
        end
        default: begin
          arrived_o <= 1'b1;
        end
      endcase
    end
  end
endmodule // rpd_arrival

// [hw/rpd_pkg.sv]
// Types shared by the preamble detector modules
// Assumes rpd_regs.svh is on the include path
package rpd_pkg;
  typedef struct packed {
    logic       enable;
    logic       nonstd;
    logic       arrival;
    logic       afc;
    logic       coll;
    logic [6:0] thresh;
    logic [5:0] nstd_len;
    logic [31:0] pattern;
    logic [7:0] jump;
  } rpd_cfg_type;
  typedef struct packed {
    logic       detected;
    logic       by_arrival;
    logic       by_std;
    logic       by_nstd;
    logic       afc_done;
    logic       jump_reconf;
  } rpd_stat_type;
  typedef enum logic [1:0] {ARR_IDLE, ARR_COUNT, ARR_DONE} rpd_arr_state_type;
endpackage

// [hw/rpd_regs.svh]
// Register offsets, field positions, reset values and counts of the preamble detector
// Assumes inclusion by the arrival and top modules and the bench
`ifndef RPD_REGS_SVH
`define RPD_REGS_SVH
`define RPD_ADR_CTRL      8'h00
`define RPD_ADR_THRESH    8'h04
`define RPD_ADR_NSTD_CFG  8'h08
`define RPD_ADR_PATTERN   8'h0C
`define RPD_ADR_JUMP      8'h10
`define RPD_ADR_STATUS    8'h14
`define RPD_CTRL_ENABLE   0
`define RPD_CTRL_NSTD     1
`define RPD_CTRL_ARRIVAL  2
`define RPD_CTRL_AFC      3
`define RPD_CTRL_RESTART  4
`define RPD_CTRL_COLL     5
`define RPD_THRESH_RST    7'h14
`define RPD_NSTD_LEN_RST  6'h08
`define RPD_PATTERN_RST   32'h000000AA
`define RPD_JUMP_RST      8'h10
`define RPD_ARR_BITS      5'h08
`define RPD_ARR_AFC_BITS  5'h10
`define RPD_ARR_MIN_TOG   5'h06
`endif

// [hw/rpd_top.sv]
// Preamble qualification: signal arrival, standard and pattern detectors
// Assumes bit strobes from bit clock recovery and a classic Wishbone master
//
// Operation
// - Arrival detector recognises preamble within one byte
// - With correction, arrival plus one-shot in two bytes
// - Arrival detector uses signal strength jump detector
// - Standard preamble when alternating count reaches threshold
// - Qualify preamble before sync word and payload
// - Threshold for standard only; pattern for nonstandard
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/10ps
`include "rpd_regs.svh"
module rpd_top
  import rpd_pkg::*;
#(
  parameter int PAT_W = 32
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  // Wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O,
  // Receive stream
  input  wire logic        RX_ON_I,
  input  wire logic        RX_BIT_I,
  input  wire logic        RX_BIT_VLD_I,
  input  wire logic [7:0]  RSSI_I,
  // Detection results
  output logic             PREAMBLE_DET_O,
  output logic             SYNC_SEARCH_EN_O,
  output logic             ARRIVAL_O,
  output logic             AFC_SHOT_O
);
  rpd_cfg_type  cfg_r;
  rpd_stat_type stat_r;
  logic             restart_r;
  logic [6:0]       cnt_r;
  logic [6:0]       cnt_nxt;
  logic             prev_r;
  logic             have_prev_r;
  logic [PAT_W-1:0] hist_r;
  logic [PAT_W-1:0] mask;
  logic [5:0]       hist_cnt_r;
  logic             std_hit;
  logic             nstd_hit;
  logic             arr_hit;
  logic             afc_shot;
  logic             clear;
  logic             wr;
  logic [31:0]      rd_nxt;

  assign clear = restart_r || !RX_ON_I || !cfg_r.enable;
  assign wr    = CYC_I && STB_I && WE_I && !ACK_O;

  // Bus acknowledge, one cycle after the request
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= CYC_I && STB_I && !ACK_O;
    end
  end

  // Configuration writes
  always_ff @(posedge CLK_I) begin
    restart_r <= 1'b0;
    if (SYS_RST_I) begin
      cfg_r.enable   <= 1'b0;
      cfg_r.nonstd   <= 1'b0;
      cfg_r.arrival  <= 1'b0;
      cfg_r.afc      <= 1'b0;
      cfg_r.coll     <= 1'b0;
      cfg_r.thresh   <= `RPD_THRESH_RST;
      cfg_r.nstd_len <= `RPD_NSTD_LEN_RST;
      cfg_r.pattern  <= `RPD_PATTERN_RST;
      cfg_r.jump     <= `RPD_JUMP_RST;
    end else if (wr && SEL_I[0]) begin
      if (ADR_I == `RPD_ADR_CTRL) begin
        cfg_r.enable  <= DAT_I[`RPD_CTRL_ENABLE];
        cfg_r.nonstd  <= DAT_I[`RPD_CTRL_NSTD];
        cfg_r.arrival <= DAT_I[`RPD_CTRL_ARRIVAL];
        cfg_r.afc     <= DAT_I[`RPD_CTRL_AFC];
        cfg_r.coll    <= DAT_I[`RPD_CTRL_COLL];
        restart_r     <= DAT_I[`RPD_CTRL_RESTART];
      end else if (ADR_I == `RPD_ADR_THRESH) begin
        cfg_r.thresh <= DAT_I[6:0];
      end else if (ADR_I == `RPD_ADR_NSTD_CFG) begin
        cfg_r.nstd_len <= DAT_I[5:0];
      end else if (ADR_I == `RPD_ADR_PATTERN) begin
        cfg_r.pattern <= DAT_I;
      end else if (ADR_I == `RPD_ADR_JUMP) begin
        cfg_r.jump <= DAT_I[7:0];
      end
    end
  end

  // Read multiplexer, unmapped reads as zero
  always_comb begin
    rd_nxt = 32'h00000000;
    if (ADR_I == `RPD_ADR_CTRL) begin
      rd_nxt[5:0] = {cfg_r.coll, 1'b0, cfg_r.afc, cfg_r.arrival, cfg_r.nonstd,
                     cfg_r.enable};
    end else if (ADR_I == `RPD_ADR_THRESH) begin
      rd_nxt[6:0] = cfg_r.thresh;
    end else if (ADR_I == `RPD_ADR_NSTD_CFG) begin
      rd_nxt[5:0] = cfg_r.nstd_len;
    end else if (ADR_I == `RPD_ADR_PATTERN) begin
      rd_nxt = cfg_r.pattern;
    end else if (ADR_I == `RPD_ADR_JUMP) begin
      rd_nxt[7:0] = cfg_r.jump;
    end else if (ADR_I == `RPD_ADR_STATUS) begin
      rd_nxt[5:0]  = stat_r;
      rd_nxt[14:8] = cnt_r;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      DAT_O <= 32'h00000000;
    end else if (CYC_I && STB_I && !ACK_O) begin
      DAT_O <= rd_nxt;
    end
  end

  // Consecutive alternating bit counter
  always_comb begin
    cnt_nxt = cnt_r;
    if (RX_BIT_VLD_I) begin
      if (have_prev_r && RX_BIT_I != prev_r) begin
        cnt_nxt = (cnt_r == 7'h7F) ? cnt_r : cnt_r + 7'h01;
      end else begin
        cnt_nxt = 7'h01;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || clear) begin
      cnt_r       <= 7'h00;
      prev_r      <= 1'b0;
      have_prev_r <= 1'b0;
      hist_r      <= '0;
      hist_cnt_r  <= 6'h00;
    end else if (RX_BIT_VLD_I) begin
      cnt_r       <= cnt_nxt;
      prev_r      <= RX_BIT_I;
      have_prev_r <= 1'b1;
      hist_r      <= {hist_r[PAT_W-2:0], RX_BIT_I};
      hist_cnt_r  <= (hist_cnt_r == 6'h3F) ? hist_cnt_r : hist_cnt_r + 6'h01;
    end
  end

  // Pattern length mask for the nonstandard match
  for (genvar i = 0; i < PAT_W; i++) begin : g_mask
    assign mask[i] = (i < int'(cfg_r.nstd_len));
  end

  assign std_hit  = !cfg_r.nonstd && cnt_r >= cfg_r.thresh;
  assign nstd_hit = cfg_r.nonstd && cfg_r.nstd_len != 6'h00
                    && hist_cnt_r >= cfg_r.nstd_len
                    && ((hist_r ^ cfg_r.pattern[PAT_W-1:0]) & mask) == '0;

  rpd_arrival u_arrival (
    .clk_i      (CLK_I),
    .rst_i      (SYS_RST_I),
    .clear_i    (clear || !cfg_r.arrival),
    .afc_i      (cfg_r.afc),
    .jump_i     (cfg_r.jump),
    .rssi_i     (RSSI_I),
    .bit_i      (RX_BIT_I),
    .bit_vld_i  (RX_BIT_VLD_I),
    .arrived_o  (arr_hit),
    .afc_shot_o (afc_shot)
  );

  // Sticky detection status until restart, disable or receiver off
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || clear) begin
      stat_r <= '0;
    end else begin
      if (!stat_r.detected && (std_hit || nstd_hit || arr_hit)) begin
        stat_r.detected   <= 1'b1;
        stat_r.by_std     <= std_hit;
        stat_r.by_nstd    <= nstd_hit;
        stat_r.by_arrival <= arr_hit;
        stat_r.jump_reconf <= arr_hit && cfg_r.coll;
      end
      if (afc_shot) begin
        stat_r.afc_done <= 1'b1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      PREAMBLE_DET_O   <= 1'b0;
      SYNC_SEARCH_EN_O <= 1'b0;
      ARRIVAL_O        <= 1'b0;
      AFC_SHOT_O       <= 1'b0;
    end else begin
      PREAMBLE_DET_O   <= stat_r.detected && !clear;
      SYNC_SEARCH_EN_O <= stat_r.detected && !clear;
      ARRIVAL_O        <= arr_hit;
      AFC_SHOT_O       <= afc_shot;
    end
  end
endmodule // rpd_top

// [sim/rpd_top_assertions.sv]
// Port checker of the preamble detector
// Assumes binding onto rpd_top, one clock
`timescale 1ns/10ps
module rpd_top_assertions #(
  parameter int PAT_W = 32
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Bus
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic ACK_O,
  // Receive and results
  input wire logic RX_ON_I,
  input wire logic PREAMBLE_DET_O,
  input wire logic SYNC_SEARCH_EN_O,
  input wire logic ARRIVAL_O,
  input wire logic AFC_SHOT_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence req; CYC_I && STB_I && !ACK_O; endsequence
  sequence quiet; RX_ON_I && !(CYC_I && WE_I); endsequence
  sequence rx_off2; !RX_ON_I ##1 !RX_ON_I; endsequence
  chk_ack_answer: assert property (req |=> ACK_O) else $error("ack missing");
  chk_ack_single: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  chk_ack_cause: assert property (!(CYC_I && STB_I) |=> !ACK_O) else $error("stray ack");
  chk_det_sync: assert property (PREAMBLE_DET_O |-> SYNC_SEARCH_EN_O)
    else $error("sync search off");
  chk_det_off: assert property (rx_off2 |=> !PREAMBLE_DET_O)
    else $error("detect while off");
  chk_det_sticky: assert property (quiet ##1 PREAMBLE_DET_O ##0 quiet ##1 quiet |-> PREAMBLE_DET_O)
    else $error("detect dropped");
  chk_arr_off: assert property (rx_off2 |=> !ARRIVAL_O && !AFC_SHOT_O)
    else $error("arrival while off");
  chk_afc_single: assert property (AFC_SHOT_O |=> !AFC_SHOT_O)
    else $error("afc pulse long");
  chk_afc_arrival: assert property (AFC_SHOT_O |-> ##[0:2] ARRIVAL_O)
    else $error("afc without arrival");
endmodule // rpd_top_assertions
bind rpd_top rpd_top_assertions #(.PAT_W(PAT_W)) rpd_top_assertions_i (.CLK_I(CLK_I),
  .SYS_RST_I(SYS_RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ACK_O(ACK_O),
  .RX_ON_I(RX_ON_I), .PREAMBLE_DET_O(PREAMBLE_DET_O), .SYNC_SEARCH_EN_O(SYNC_SEARCH_EN_O),
  .ARRIVAL_O(ARRIVAL_O), .AFC_SHOT_O(AFC_SHOT_O));

// [sim/rpd_top_test.sv]
// Self-checking bench of rpd_top with a transmitter model
// Assumes rpd_pkg and rpd_regs.svh compiled first
`timescale 1ns/10ps
`include "rpd_regs.svh"
module rpd_top_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, rx_on = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat = 32'h0, q, dat_o, thr = 32'h0, pat = 32'h0, sh = 32'h0;
  logic        ack, det, sync, arr, afc, rx_bit, rx_vld, lst, nstd, mdet, d1, d2, arr_s;
  logic [7:0]  rssi;
  int          errors = 0, checks = 0, seed = 32'hd4ca, cnt, chk_on = 0, afc_n;
  logic [7:0]  ra[6] = '{`RPD_ADR_CTRL, `RPD_ADR_THRESH, `RPD_ADR_NSTD_CFG,
                         `RPD_ADR_PATTERN, `RPD_ADR_JUMP, 8'h18};
  logic [31:0] rv[6] = '{32'h0, `RPD_THRESH_RST, `RPD_NSTD_LEN_RST, `RPD_PATTERN_RST,
                         `RPD_JUMP_RST, 32'h0};
  always #12.5 clk = ~clk;
  rpd_top rpd_top_i (.CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .RX_ON_I(rx_on),
    .RX_BIT_I(rx_bit), .RX_BIT_VLD_I(rx_vld), .RSSI_I(rssi), .PREAMBLE_DET_O(det),
    .SYNC_SEARCH_EN_O(sync), .ARRIVAL_O(arr), .AFC_SHOT_O(afc));
  rpd_tx_model rpd_tx_model_i (.clk_i(clk), .bit_o(rx_bit), .vld_o(rx_vld), .rssi_o(rssi));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    {cyc, stb} <= 2'b00;
    if (n >= 20) begin
      errors++;
      report_and_stop;
    end
  endtask
  // Restart with new control, clear the model
  task automatic ctrl(input logic [31:0] d);
    chk_on = 0;
    wb(1, `RPD_ADR_CTRL, d | 32'h10, 4'h1);
    wb(0, `RPD_ADR_CTRL, 0, 4'hF);
    cmp(q, d);
    nstd = d[1];
    {cnt, mdet, d1, d2, sh, arr_s, afc_n} = '0;
    chk_on = !d[2];
  endtask
  task automatic chk_stat;
    wb(0, `RPD_ADR_STATUS, 0, 4'hF);
    cmp({q[14:8], q[3:2], q[5]}, {cnt[6:0], !nstd & mdet, nstd & mdet, mdet});
  endtask
  // Reference model, detect shows two edges after the bit
  always @(posedge clk) begin
    if (chk_on) cmp({det, sync}, {d2, d2});
    d2 = d1;
    d1 = mdet;
    arr_s = arr_s | arr;
    afc_n = afc_n + afc;
    if (rx_vld && rx_on) begin
      cnt = (cnt != 0 && rx_bit != lst) ? (cnt < 127 ? cnt + 1 : 127) : 1;
      lst = rx_bit;
      sh = {sh[30:0], rx_bit};
      if (nstd ? ((sh ^ pat) & 32'hFF) == 0 : cnt >= thr) mdet = 1;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rx_on <= 1'b1;
    wb(1, 8'h18, 32'hFFFF, 4'hF);
    for (int i = 0; i < 6; i++) begin
      wb(1, ra[i], 32'h5A5A5A5A, 4'hE);
      wb(0, ra[i], 0, 4'hF);
      cmp(q, rv[i]);
    end
    for (int k = 0; k < 5; k++) begin
      thr = k == 0 ? 20 : k == 1 ? 1 : k == 2 ? 127 : 2 + $unsigned($random(seed)) % 40;
      wb(1, `RPD_ADR_THRESH, thr, 4'h1);
      ctrl(32'h1);
      rpd_tx_model_i.send(thr / 2 + 1, 32'h2, 2, 1 + k % 3);
      rpd_tx_model_i.send(2, 32'h3, 2, 1);
      rpd_tx_model_i.send(thr + 2, 32'h2, 2, 1 + k % 3);
      rpd_tx_model_i.idle;
      chk_stat;
      chk_on = 0;
      rx_on <= 1'b0;
      repeat (3) @(posedge clk);
      cmp(det, 0);
      rx_on <= 1'b1;
    end
    thr = 1;
    pat = $random(seed) | 32'h80;
    wb(1, `RPD_ADR_THRESH, thr, 4'h1);
    wb(1, `RPD_ADR_NSTD_CFG, 32'h8, 4'h1);
    wb(1, `RPD_ADR_PATTERN, pat, 4'h1);
    ctrl(32'h3);
    rpd_tx_model_i.send(8, ~pat, 8, 2);
    rpd_tx_model_i.send(16, pat, 8, 1);
    rpd_tx_model_i.idle;
    chk_stat;
    // Highest threshold keeps the standard detector out of arrival runs
    thr = 127;
    wb(1, `RPD_ADR_THRESH, thr, 4'h1);
    for (int k = 0; k < 3; k++) begin
      wb(1, `RPD_ADR_JUMP, k == 2 ? 32'hFF : 32'h10, 4'h1);
      ctrl(k == 1 ? 32'h2D : 32'h25);
      rpd_tx_model_i.send(k == 1 ? 16 : 8, 32'h2, 2, 1);
      repeat (4) @(posedge clk);
      cmp({arr_s, afc_n[1:0]}, {k < 2, 2'(k == 1)});
      wb(0, `RPD_ADR_STATUS, 0, 4'hF);
      cmp({q[5:4], q[1:0]}, {k < 2, k < 2, k == 1, k < 2});
      rpd_tx_model_i.idle;
    end
    // Zero threshold, last preamble byte ahead of a two byte sync word
    thr = 0;
    wb(1, `RPD_ADR_THRESH, thr, 4'h1);
    ctrl(32'h5);
    rpd_tx_model_i.send(24, 32'hAA2DD4, 24, 1);
    rpd_tx_model_i.idle;
    chk_stat;
    report_and_stop;
  end
endmodule // rpd_top_test

// [sim/rpd_tx_model.sv]
// Remote transmitter sending preamble bits as strobes
// Assumes the bench calls its tasks after reset
`timescale 1ns/10ps
module rpd_tx_model (
  // Clock
  input  wire logic clk_i,
  // Air side
  output logic       bit_o,
  output logic       vld_o,
  output logic [7:0] rssi_o
);
  initial begin
    bit_o = 1'b0;
    vld_o = 1'b0;
    rssi_o = 8'h10;
  end
  // Repeats low plen bits of pat, oldest first
  task automatic send(input int n, input logic [31:0] pat, input int plen, input int gap);
    rssi_o <= 8'h80;
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge clk_i);
      bit_o <= pat[plen - 1 - i % plen];
      vld_o <= 1'b1;
      @(posedge clk_i);
      vld_o <= 1'b0;
      bit_o <= ~bit_o;
    end
  endtask
  task automatic idle;
    @(posedge clk_i);
    rssi_o <= 8'h10;
  endtask
endmodule // rpd_tx_model
